//--- rtl/imm_defines.svh
`ifndef IMM_DEFINES_SVH
`define IMM_DEFINES_SVH

// byte address of the memory map register on the local bus
`define IMM_MAP_ADDR       4'h0
// address bits decoded by the slave
`define IMM_ADDR_W         4
// bit positions, counted from the lsb
`define IMM_LS_ON_BIT      0
`define IMM_LS_PLACE_LO    8
`define IMM_LS_PLACE_HI    9
`define IMM_IB_ON_BIT      16
`define IMM_CROSS_BIT      17
`define IMM_IB_PLACE_LO    24
`define IMM_IB_PLACE_HI    25
// writable bits
`define IMM_WR_MASK        32'h0303_0301
// fixed reset values
`define IMM_IB_ON_RST      1'b0
`define IMM_CROSS_RST      1'b1
// axi responses
`define IMM_RESP_OKAY      2'b00
`define IMM_RESP_SLVERR    2'b10
// axi privileged bit of prot
`define IMM_PROT_PRIV      0

`endif

//--- rtl/imm_pkg.sv
package imm_pkg;
  typedef logic [1:0] imm_place_t;
  typedef enum logic [1:0] {
    IMM_REGION_LOW_START  = 2'b00,
    IMM_REGION_LOW_END    = 2'b01,
    IMM_REGION_HIGH_START = 2'b10,
    IMM_REGION_HIGH_END   = 2'b11
  } imm_region_t;
endpackage

//--- rtl/imm_map_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "imm_defines.svh"

module imm_map_ctrl
  import imm_pkg::*;
#(
  parameter bit HAS_IBUS_MEM = 1'b1
) (
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire logic                   clk_en,
  input  wire logic                   cfg_ls_on,
  input  wire logic [1:0]             cfg_ls_place,
  input  wire logic [1:0]             cfg_ib_place,
  input  wire logic [`IMM_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]             s_axi_awprot,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [`IMM_ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]             s_axi_arprot,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  output logic                        ls_block_on,
  output logic [1:0]                  ls_block_place,
  output logic                        ib_block_on,
  output logic [1:0]                  ib_block_place,
  output logic                        cross_bus_data_permit
);

  logic                   cfg_on_s1_reg;
  logic                   cfg_on_s2_reg;
  logic [1:0]             cfg_lp_s1_reg;
  logic [1:0]             cfg_lp_s2_reg;
  logic [1:0]             cfg_ip_s1_reg;
  logic [1:0]             cfg_ip_s2_reg;
  logic                   lsbus_block_on_reg;
  imm_place_t             lsbus_block_place_reg;
  logic                   ibus_block_on_reg;
  imm_place_t             ibus_block_place_reg;
  logic                   cross_bus_data_permit_reg;
  logic                   aw_held_reg;
  logic [`IMM_ADDR_W-1:0] aw_addr_reg;
  logic                   aw_priv_reg;
  logic                   w_held_reg;
  logic [31:0]            w_data_reg;
  logic [3:0]             w_strb_reg;
  logic                   bvalid_reg;
  logic [1:0]             bresp_reg;
  logic                   rvalid_reg;
  logic [1:0]             rresp_reg;
  logic [31:0]            rdata_reg;
  logic [31:0]            map_word;
  logic [31:0]            map_next;
  logic                   wr_fire;
  logic                   wr_ok;
  logic                   rd_fire;
  logic                   ib_eff_on;
  logic                   clash;

  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  function automatic logic access_ok(input logic [`IMM_ADDR_W-1:0] a, input logic priv);
    access_ok = (a == `IMM_MAP_ADDR) && priv;
  endfunction

  // configuration word synchronisers
  always_ff @(posedge clk) begin
    if (clk_en) begin
      cfg_on_s1_reg <= cfg_ls_on;
      cfg_on_s2_reg <= cfg_on_s1_reg;
      cfg_lp_s1_reg <= cfg_ls_place;
      cfg_lp_s2_reg <= cfg_lp_s1_reg;
      cfg_ip_s1_reg <= cfg_ib_place;
      cfg_ip_s2_reg <= cfg_ip_s1_reg;
    end
  end

  always_comb begin
    map_word = '0;
    map_word[`IMM_LS_ON_BIT] = lsbus_block_on_reg;
    map_word[`IMM_LS_PLACE_HI:`IMM_LS_PLACE_LO] = lsbus_block_place_reg;
    map_word[`IMM_IB_ON_BIT] = ibus_block_on_reg;
    map_word[`IMM_CROSS_BIT] = cross_bus_data_permit_reg;
    map_word[`IMM_IB_PLACE_HI:`IMM_IB_PLACE_LO] = ibus_block_place_reg;
  end

  assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
  assign wr_ok   = access_ok(aw_addr_reg, aw_priv_reg);
  assign map_next = (map_word & ~(strb_mask(w_strb_reg) & `IMM_WR_MASK))
                  | (w_data_reg & strb_mask(w_strb_reg) & `IMM_WR_MASK);

  always_ff @(posedge clk) begin
    if (reset) begin
      if (clk_en) begin
        lsbus_block_on_reg    <= cfg_on_s2_reg;
        lsbus_block_place_reg <= cfg_lp_s2_reg;
        ibus_block_place_reg  <= cfg_ip_s2_reg;
      end
    end else if (clk_en && wr_fire && wr_ok) begin
      lsbus_block_on_reg    <= map_next[`IMM_LS_ON_BIT];
      lsbus_block_place_reg <= map_next[`IMM_LS_PLACE_HI:`IMM_LS_PLACE_LO];
      ibus_block_place_reg  <= map_next[`IMM_IB_PLACE_HI:`IMM_IB_PLACE_LO];
    end
  end

  always_ff @(posedge clk) begin
    if (clk_en && reset) begin
      ibus_block_on_reg         <= `IMM_IB_ON_RST;
      cross_bus_data_permit_reg <= `IMM_CROSS_RST;
    end else if (clk_en && wr_fire && wr_ok) begin
      ibus_block_on_reg         <= map_next[`IMM_IB_ON_BIT];
      cross_bus_data_permit_reg <= map_next[`IMM_CROSS_BIT];
    end
  end

  // write channels
  always_ff @(posedge clk) begin
    if (clk_en && reset) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
      aw_priv_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      w_data_reg  <= '0;
      w_strb_reg  <= '0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `IMM_RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
        aw_priv_reg <= s_axi_awprot[`IMM_PROT_PRIV];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_ok ? `IMM_RESP_OKAY : `IMM_RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready  = !w_held_reg && !bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;

  // read channel
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  always_ff @(posedge clk) begin
    if (clk_en && reset) begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= `IMM_RESP_OKAY;
      rdata_reg  <= '0;
    end else if (clk_en) begin
      if (rd_fire) begin
        rvalid_reg <= 1'b1;
        if (access_ok(s_axi_araddr, s_axi_arprot[`IMM_PROT_PRIV])) begin
          rresp_reg <= `IMM_RESP_OKAY;
          rdata_reg <= map_word;
        end else begin
          rresp_reg <= `IMM_RESP_SLVERR;
          rdata_reg <= '0;
        end
      end else if (rvalid_reg && s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;

  assign ib_eff_on = ibus_block_on_reg && HAS_IBUS_MEM;
  assign clash = lsbus_block_on_reg && ib_eff_on
              && (lsbus_block_place_reg == ibus_block_place_reg);

  assign ls_block_on           = lsbus_block_on_reg && !clash;
  assign ib_block_on           = ib_eff_on && !clash;
  assign ls_block_place        = lsbus_block_place_reg;
  assign ib_block_place        = ibus_block_place_reg;
  assign cross_bus_data_permit = cross_bus_data_permit_reg;

  AST_CLASH_OFF: assert property (@(posedge clk) disable iff (reset)
    (lsbus_block_on_reg && ib_eff_on && lsbus_block_place_reg == ibus_block_place_reg)
    |-> (!ls_block_on && !ib_block_on)) else $error("conflict left a block on");
  AST_NO_CLASH: assert property (@(posedge clk) disable iff (reset)
    !clash |-> (ib_block_on == ib_eff_on)) else $error("ib enable wrong");
  AST_LS_ON: assert property (@(posedge clk) disable iff (reset)
    !clash |-> (ls_block_on == map_word[`IMM_LS_ON_BIT])) else $error("ls enable wrong");
  AST_LS_ON_WR: assert property (@(posedge clk) disable iff (reset)
    (clk_en && wr_fire && wr_ok && w_strb_reg[`IMM_LS_ON_BIT/8])
    |=> lsbus_block_on_reg == $past(w_data_reg[`IMM_LS_ON_BIT]))
    else $error("ls enable not written");
  AST_LS_PLACE: assert property (@(posedge clk) disable iff (reset)
    (clk_en && wr_fire && wr_ok && w_strb_reg[`IMM_LS_PLACE_LO/8])
    |=> ls_block_place == $past(w_data_reg[`IMM_LS_PLACE_HI:`IMM_LS_PLACE_LO]))
    else $error("ls place not written");
  AST_IB_PLACE: assert property (@(posedge clk) disable iff (reset)
    (clk_en && wr_fire && wr_ok && w_strb_reg[`IMM_IB_PLACE_LO/8])
    |=> ib_block_place == $past(w_data_reg[`IMM_IB_PLACE_HI:`IMM_IB_PLACE_LO]))
    else $error("ib place not written");
  AST_IB_ON_WR: assert property (@(posedge clk) disable iff (reset)
    (clk_en && wr_fire && wr_ok && w_strb_reg[`IMM_IB_ON_BIT/8])
    |=> ibus_block_on_reg == $past(w_data_reg[`IMM_IB_ON_BIT]))
    else $error("ib enable not written");
  AST_IB_ABSENT: assert property (@(posedge clk) disable iff (reset)
    !HAS_IBUS_MEM |-> !ib_block_on) else $error("absent ib memory enabled");
  AST_CROSS_RST: assert property (@(posedge clk)
    $fell(reset) |-> cross_bus_data_permit) else $error("permit not set after reset");
  AST_CROSS_WR: assert property (@(posedge clk) disable iff (reset)
    (clk_en && wr_fire && wr_ok && w_strb_reg[`IMM_CROSS_BIT/8])
    |=> cross_bus_data_permit == $past(w_data_reg[`IMM_CROSS_BIT]))
    else $error("permit not written");
  // configuration loaded once synchronisers are filled
  AST_CFG_LOAD: assert property (@(posedge clk)
    (reset && clk_en && $past(reset && clk_en) && $past(reset && clk_en, 2))
    |=> (lsbus_block_on_reg == $past(cfg_on_s2_reg)
      && lsbus_block_place_reg == $past(cfg_lp_s2_reg)
      && ibus_block_place_reg == $past(cfg_ip_s2_reg)))
    else $error("config not loaded");
  AST_USER_WR: assert property (@(posedge clk) disable iff (reset)
    (clk_en && wr_fire && !aw_priv_reg)
    |=> (bresp_reg == `IMM_RESP_SLVERR && $stable(map_word)))
    else $error("user write accepted");
  AST_USER_RD: assert property (@(posedge clk) disable iff (reset)
    (clk_en && rd_fire && !s_axi_arprot[`IMM_PROT_PRIV])
    |=> (s_axi_rresp == `IMM_RESP_SLVERR && s_axi_rdata == 32'h0000_0000))
    else $error("user read accepted");
  AST_BAD_ADDR: assert property (@(posedge clk) disable iff (reset)
    (clk_en && wr_fire && aw_addr_reg != `IMM_MAP_ADDR)
    |=> (bresp_reg == `IMM_RESP_SLVERR && $stable(map_word)))
    else $error("unmapped write accepted");
  AST_BRESP_OK: assert property (@(posedge clk) disable iff (reset)
    (clk_en && wr_fire && wr_ok) |=> (s_axi_bvalid && s_axi_bresp == `IMM_RESP_OKAY))
    else $error("supervisor write refused");
  AST_RD_DATA: assert property (@(posedge clk) disable iff (reset)
    (clk_en && rd_fire && access_ok(s_axi_araddr, s_axi_arprot[`IMM_PROT_PRIV]))
    |=> s_axi_rdata == $past(map_word)) else $error("read data wrong");
  AST_RSV_ZERO: assert property (@(posedge clk) disable iff (reset)
    (map_word & ~`IMM_WR_MASK) == 32'h0000_0000) else $error("reserved bit set");

  COV_WRITE:   cover property (@(posedge clk) disable iff (reset) wr_fire && wr_ok);
  COV_READ:    cover property (@(posedge clk) disable iff (reset) rd_fire);
  COV_CLASH:   cover property (@(posedge clk) disable iff (reset) clash);
  COV_DENY:    cover property (@(posedge clk) disable iff (reset) wr_fire && !wr_ok);
  COV_USER_RD: cover property (@(posedge clk) disable iff (reset)
    rd_fire && !s_axi_arprot[`IMM_PROT_PRIV]);

endmodule // imm_map_ctrl

`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "imm_defines.svh"

module tb;
  import imm_pkg::*;
  logic        clk, reset, awv, wv, arv, awr, wr, bv, arr, rv, lo, io, pm, brdy, rrdy;
  logic [3:0]  awa, ara, ws;
  logic [2:0]  awp, arp;
  logic [31:0] wd, rd, d;
  logic [1:0]  br, rr, lp, ip, r;
  int          num_errors, n_tests, i;

  imm_map_ctrl uut (.clk(clk), .reset(reset), .clk_en(1'b1), .cfg_ls_on(1'b1),
    .cfg_ls_place(2'h2), .cfg_ib_place(2'h1), .s_axi_awaddr(awa), .s_axi_awprot(awp),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
    .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(brdy), .s_axi_araddr(ara), .s_axi_arprot(arp), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rrdy), .ls_block_on(lo), .ls_block_place(lp), .ib_block_on(io),
    .ib_block_place(ip), .cross_bus_data_permit(pm));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic print_verdict();
    $display("checks=%0d errors=%0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // expected outputs, conflict gating included
  function automatic logic [31:0] ex(logic l, logic [1:0] a, logic b, logic [1:0] c, logic p);
    logic k;
    k = l && b && (a == c);
    return {25'h0, l & ~k, a, b & ~k, c, p};
  endfunction

  task automatic chk_out(input logic [31:0] e);
    chk({25'h0, lo, lp, io, ip, pm}, e);
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [2:0] p, input logic [31:0] v,
                        input logic [3:0] s);
    int  n;
    bit  ao, wo, bo;
    awa <= a; awp <= p; wd <= v; ws <= s; awv <= 1'b1; wv <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge clk);
      ao = awv && awr;
      wo = wv && wr;
      bo = bv;
      r  = br;
      @(posedge clk);
      if (ao) awv <= 1'b0;
      if (wo) wv <= 1'b0;
      if (bo) break;
    end
    if (n == 50) begin
      num_errors++;
      print_verdict();
    end
  endtask

  task automatic axi_rd(input logic [3:0] a, input logic [2:0] p);
    int  n;
    bit  ao, ro;
    ara <= a; arp <= p; arv <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge clk);
      ao = arv && arr;
      ro = rv;
      d  = rd;
      r  = rr;
      @(posedge clk);
      if (ao) arv <= 1'b0;
      if (ro) break;
    end
    if (n == 50) begin
      num_errors++;
      print_verdict();
    end
  endtask

  initial begin
    num_errors = 0; n_tests = 0; reset = 1'b1;
    awv = 0; wv = 0; arv = 0; awa = 0; ara = 0; awp = 0; arp = 0; wd = 0; ws = 0;
    brdy = 1'b1;
    rrdy = 1'b1;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    axi_rd(4'h0, 3'h1);
    chk(d, 32'h0102_0201);
    chk_out(ex(1'b1, 2'h2, 1'b0, 2'h1, 1'b1));
    axi_wr(4'h0, 3'h1, 32'hffff_ffff, 4'hf);
    chk({30'h0, r}, {30'h0, `IMM_RESP_OKAY});
    axi_rd(4'h0, 3'h1);
    chk(d, 32'h0303_0301);
    chk_out(ex(1'b1, 2'h3, 1'b1, 2'h3, 1'b1));
    for (i = 0; i < 4; i++) begin
      axi_wr(4'h0, 3'h1, {6'h0, 2'(i + 1), 6'h0, 2'b01, 6'h0, 2'(i), 7'h0, 1'b1}, 4'hf);
      axi_rd(4'h0, 3'h1);
      chk_out(ex(1'b1, 2'(i), 1'b1, 2'(i + 1), 1'b0));
      axi_wr(4'h0, 3'h1, {6'h0, 2'(i), 6'h0, 2'b10, 6'h0, 2'(i), 7'h0, 1'b1}, 4'hf);
      axi_rd(4'h0, 3'h1);
      chk_out(ex(1'b1, 2'(i), 1'b0, 2'(i), 1'b1));
    end
    axi_wr(4'h0, 3'h0, 32'h0, 4'hf);
    chk({30'h0, r}, {30'h0, `IMM_RESP_SLVERR});
    axi_rd(4'h0, 3'h0);
    chk({30'h0, r}, {30'h0, `IMM_RESP_SLVERR});
    chk(d, 32'h0000_0000);
    axi_rd(4'h0, 3'h1);
    chk(d, 32'h0302_0301);
    axi_wr(4'h4, 3'h1, 32'h0, 4'hf);
    chk({30'h0, r}, {30'h0, `IMM_RESP_SLVERR});
    axi_rd(4'h4, 3'h1);
    chk({30'h0, r}, {30'h0, `IMM_RESP_SLVERR});
    axi_wr(4'h0, 3'h1, 32'h0, 4'hf);
    axi_rd(4'h0, 3'h1);
    chk_out(ex(1'b0, 2'h0, 1'b0, 2'h0, 1'b0));
    axi_wr(4'h0, 3'h1, 32'hffff_ffff, 4'h2);
    axi_rd(4'h0, 3'h1);
    chk(d, 32'h0000_0300);
    chk_out(ex(1'b0, 2'h3, 1'b0, 2'h0, 1'b0));
    print_verdict();
  end
endmodule // tb

`default_nettype wire
